/* hw/smcc_top.sv */
/*
  Call-control sequencer for a serial port driving an external modem.
  Assumes a same-clock UART on tx/rx, and raw modem leads on the pins.
*/
`timescale 1ns/100ps
module smcc_top import smcc_pkg::*; #(
  parameter logic [33:0] TMO_CYC   = CONN_TMO_CYC,
  parameter logic [31:0] GSTEP_CYC = GUARD_STEP_CYC,
  parameter int          FIFO_D    = 4
) (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  output logic [7:0]       tx_data,
  output logic             tx_valid,
  input  wire logic        tx_ready,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_valid,
  input  wire logic        cd_pin,
  input  wire logic        set_ready_pin,
  input  wire logic        ring_pin,
  output logic             link_up
);
  typedef enum logic [3:0] {
    ST_IDLE, ST_PRE, ST_NUM, ST_CR, ST_LF, ST_WAIT, ST_ONLINE,
    ST_GUARD1, ST_ESC, ST_GUARD2, ST_DISC
  } smcc_st_e;

  smcc_st_e    st_r, st_nxt;
  smcc_op_e    op_r, op_nxt;
  logic [1:0]  mode_r;
  logic        dialin_r;
  logic [2:0]  guard_r;
  logic [7:0]  mem_r [NSTR][STR_MAX];
  logic [4:0]  len_r [NSTR];
  logic [4:0]  idx_r, src_len, mt_r;
  logic [7:0]  src_byte;
  logic [33:0] tmr_r, guard_lim;
  logic        timeout_r, lost_r, ring_d_r;
  logic [2:0]  s1_r, s2_r;
  logic        cd_s, set_ready_s, ring_s;
  logic        c_wr;
  logic [7:0]  c_byte;
  logic        f_ready, f_empty, push, sending, done;
  logic        user, active, dial_req, hang_req, ring_rise;
  logic        use_cd, conn_seen, est, guard_done, loss;
  smcc_st_e    hang_st;

  ////////////////////////////////////////////////////////////////
  // pin synchronisers: first stage feeds only the second
  genvar gi;
  for (gi = 0; gi < 3; gi++) begin : g_sync
    always_ff @(posedge clk) begin
      if (srst) begin
        s1_r[gi] <= 1'b0;
        s2_r[gi] <= 1'b0;
      end else begin
        s1_r[gi] <= (gi == 0) ? cd_pin : (gi == 1) ? set_ready_pin : ring_pin;
        s2_r[gi] <= s1_r[gi];
      end
    end
  end
  assign cd_s        = s2_r[0];
  assign set_ready_s = s2_r[1];
  assign ring_s      = s2_r[2];

  always_ff @(posedge clk) begin
    if (srst) ring_d_r <= 1'b0;
    else ring_d_r <= ring_s;
  end
  assign ring_rise = ring_s && !ring_d_r;

  ////////////////////////////////////////////////////////////////
  // register port
  assign dial_req = reg_wr && reg_addr == REG_CMD && reg_wdata[CMD_DIAL];
  assign hang_req = reg_wr && reg_addr == REG_CMD && reg_wdata[CMD_HANG];

  always_ff @(posedge clk) begin
    if (srst) begin
      mode_r   <= MODE_OFF;
      dialin_r <= 1'b0;
      guard_r  <= '0;
    end else if (reg_wr && reg_addr == REG_CTRL) begin
      mode_r   <= reg_wdata[CTRL_MODE_LSB +: 2];
      dialin_r <= reg_wdata[CTRL_DIALIN];
      guard_r  <= (reg_wdata[CTRL_GUARD_LSB +: 3] > GUARD_MAX) ? GUARD_MAX : reg_wdata[CTRL_GUARD_LSB +: 3];
    end
  end

  smcc_caret u_caret (
    .clk      (clk),
    .srst     (srst),
    .in_wr    (reg_wr && reg_addr == REG_STR),
    .in_char  (reg_wdata[7:0]),
    .in_clr   (reg_wr && reg_addr == REG_STR && reg_wdata[STR_CLR]),
    .out_wr   (c_wr),
    .out_byte (c_byte)
  );

  // strings append one decoded byte per write, none for a caret lead-in; clear empties the selected one
  for (gi = 0; gi < NSTR; gi++) begin : g_str
    logic hit;
    assign hit = reg_wr && reg_addr == REG_STR && reg_wdata[STR_SEL_LSB +: 3] == 3'(gi);
    always_ff @(posedge clk) begin
      if (srst) len_r[gi] <= '0;
      else if (hit && reg_wdata[STR_CLR]) len_r[gi] <= '0;
      else if (hit && c_wr && len_r[gi] != 5'(STR_MAX)) len_r[gi] <= len_r[gi] + 1'b1;
    end
    always_ff @(posedge clk) begin
      if (hit && c_wr && len_r[gi] != 5'(STR_MAX)) mem_r[gi][len_r[gi]] <= c_byte;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) reg_rdata <= '0;
    else begin
      reg_rdata <= '0;
      if (reg_rd) begin
        unique case (reg_addr)
          REG_CTRL: reg_rdata <= {26'h0, guard_r, dialin_r, mode_r};
          REG_STAT: reg_rdata <= {24'h0, !f_empty, lost_r, timeout_r, link_up, 4'(st_r)};
          REG_LEN: begin
            for (int i = 0; i < NSTR; i++) reg_rdata[i*LEN_STRIDE +: 5] <= len_r[i];
          end
          default: reg_rdata <= '0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // byte source for the sending states
  // user strings only count in user mode
  assign user   = mode_r == MODE_USER;
  // command set off keeps an idle sequencer idle
  assign active = user || mode_r == MODE_STD;
  assign sending = st_r inside {ST_PRE, ST_NUM, ST_CR, ST_LF, ST_ESC, ST_DISC};

  always_comb begin
    src_len  = '0;
    src_byte = '0;
    case (st_r)
      ST_PRE: begin
        // user dial prefix or standard command head
        if (user && op_r == OP_DIAL) begin
          src_len  = len_r[STR_PRE];
          src_byte = mem_r[STR_PRE][idx_r];
        end else begin
          src_len  = STD_CMD_LEN;
          src_byte = smcc_std_byte(op_r, idx_r);
        end
      end
      ST_NUM: begin
        src_len  = len_r[STR_NUM];
        src_byte = mem_r[STR_NUM][idx_r];
      end
      ST_CR: begin
        src_len  = 5'h01;
        src_byte = CH_CR;
      end
      ST_LF: begin
        src_len  = 5'h01;
        src_byte = CH_LF;
      end
      ST_ESC: begin
        src_len  = len_r[STR_ESC];
        src_byte = mem_r[STR_ESC][idx_r];
      end
      ST_DISC: begin
        src_len  = len_r[STR_DISC];
        src_byte = mem_r[STR_DISC][idx_r];
      end
      default: ;
    endcase
  end

  assign push = sending && idx_r < src_len;
  assign done = sending && idx_r >= src_len;

  // four words of slack let the sequencer run ahead of a slow UART
  smcc_fifo #(.W(8), .D(FIFO_D)) u_fifo (
    .clk       (clk),
    .srst      (srst),
    .in_valid  (push),
    .in_ready  (f_ready),
    .in_data   (src_byte),
    .out_valid (tx_valid),
    .out_ready (tx_ready),
    .out_data  (tx_data)
  );
  assign f_empty = !tx_valid;

  always_ff @(posedge clk) begin
    if (srst || st_nxt != st_r) idx_r <= '0;
    else if (push && f_ready) idx_r <= idx_r + 1'b1;
  end

  ////////////////////////////////////////////////////////////////
  // timers: one counter serves guard and connect timeout
  // guard counts only once the queue has drained
  assign guard_lim = 34'(34'(guard_r) * 34'(GSTEP_CYC));
  assign guard_done = f_empty && tmr_r >= guard_lim;

  always_ff @(posedge clk) begin
    if (srst || st_nxt != st_r) tmr_r <= '0;
    else if (st_r inside {ST_GUARD1, ST_GUARD2} && !f_empty) tmr_r <= '0;
    else if (tmr_r != '1) tmr_r <= tmr_r + 1'b1;
  end

  // naive restart search for the connect string
  // an empty connect string falls back to carrier detect
  assign use_cd = !(user && len_r[STR_CONN] != '0);
  assign conn_seen = rx_valid && mt_r < len_r[STR_CONN] && rx_data == mem_r[STR_CONN][mt_r]
                     && mt_r == len_r[STR_CONN] - 1'b1;
  assign est = use_cd ? cd_s : conn_seen;

  always_ff @(posedge clk) begin
    if (srst || st_r != ST_WAIT || use_cd) mt_r <= '0;
    else if (rx_valid && mt_r < len_r[STR_CONN]) begin
      if (rx_data == mem_r[STR_CONN][mt_r]) mt_r <= mt_r + 1'b1;
      else if (rx_data == mem_r[STR_CONN][0]) mt_r <= 5'h01;
      else mt_r <= '0;
    end
  end

  // loss of set-ready or carrier ends the call
  assign loss = !set_ready_s || !cd_s;

  ////////////////////////////////////////////////////////////////
  // sequencer
  // user hang-up starts with the first guard
  assign hang_st = user ? ST_GUARD1 : ST_PRE;

  always_comb begin
    st_nxt = st_r;
    op_nxt = op_r;
    unique case (st_r)
      ST_IDLE: if (active) begin
        if (dial_req) begin
          st_nxt = ST_PRE;
          op_nxt = OP_DIAL;
        end else if (hang_req) begin
          st_nxt = hang_st;
          op_nxt = OP_HANG;
        end else if (ring_rise && dialin_r) begin
          st_nxt = user ? ST_WAIT : ST_PRE;
          op_nxt = OP_ANS;
        end
      end
      ST_PRE: if (done) st_nxt = (op_r == OP_DIAL) ? ST_NUM : ST_CR;
      // user dial sends only the user strings, no line end
      ST_NUM: if (done) st_nxt = user ? ST_WAIT : ST_CR;
      ST_CR: if (done) st_nxt = ST_LF;
      ST_LF: if (done) st_nxt = (op_r == OP_HANG) ? ST_IDLE : ST_WAIT;
      ST_WAIT: begin
        if (hang_req) begin
          st_nxt = hang_st;
          op_nxt = OP_HANG;
        end else if (est) st_nxt = ST_ONLINE;
        else if (tmr_r >= TMO_CYC) st_nxt = ST_IDLE;
      end
      ST_ONLINE: begin
        if (hang_req) begin
          st_nxt = hang_st;
          op_nxt = OP_HANG;
        end else if (loss) st_nxt = ST_IDLE;
      end
      ST_GUARD1: if (guard_done) st_nxt = ST_ESC;
      ST_ESC: if (done) st_nxt = ST_GUARD2;
      ST_GUARD2: if (guard_done) st_nxt = ST_DISC;
      ST_DISC: if (done) st_nxt = ST_IDLE;
      default: st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= ST_IDLE;
      op_r <= OP_DIAL;
    end else begin
      st_r <= st_nxt;
      op_r <= op_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) link_up <= 1'b0;
    else link_up <= st_nxt == ST_ONLINE;
  end

  // sticky flags, write one to clear; a same-cycle event wins
  always_ff @(posedge clk) begin
    if (srst) begin
      timeout_r <= 1'b0;
      lost_r    <= 1'b0;
    end else begin
      if (st_r == ST_WAIT && !hang_req && !est && tmr_r >= TMO_CYC) timeout_r <= 1'b1;
      else if (reg_wr && reg_addr == REG_STAT && reg_wdata[STAT_TMO]) timeout_r <= 1'b0;
      if (st_r == ST_ONLINE && !hang_req && loss) lost_r <= 1'b1;
      else if (reg_wr && reg_addr == REG_STAT && reg_wdata[STAT_LOST]) lost_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  a_off_stays_idle: assert property (st_r == ST_IDLE && !active |=> st_r == ST_IDLE && f_empty)
    else $error("command sent with command set off");
  a_std_line_end: assert property (st_r == ST_CR && push && f_ready |=>
    st_r == ST_CR ##1 st_r == ST_LF && src_byte == CH_LF) else $error("CR not followed by LF");
  a_user_dial_src: assert property (st_r == ST_PRE && user && op_r == OP_DIAL && push
    |-> src_byte == mem_r[STR_PRE][idx_r]) else $error("user prefix not used");
  a_std_no_escape: assert property (st_r == ST_IDLE && mode_r == MODE_STD && hang_req && !dial_req
    |=> st_r == ST_PRE ##0 op_r == OP_HANG) else $error("escape used in standard mode");
  a_no_answer: assert property (st_r == ST_IDLE && !dialin_r && !dial_req && !hang_req
    |=> st_r == ST_IDLE) else $error("call answered with dial-in off");
  a_empty_prefix: assert property (st_r == ST_PRE && user && op_r == OP_DIAL
    && len_r[STR_PRE] == '0 |=> st_r == ST_NUM) else $error("empty prefix not skipped");
  a_conn_timeout: assert property (st_r == ST_WAIT && !hang_req && !est && tmr_r >= TMO_CYC
    |=> st_r == ST_IDLE && timeout_r) else $error("connect timeout missed");
  a_cd_connect: assert property (st_r == ST_WAIT && use_cd && cd_s && !hang_req
    |=> link_up && st_r == ST_ONLINE) else $error("carrier not taken as connect");
  a_esc_to_guard: assert property (st_r == ST_ESC && idx_r >= len_r[STR_ESC]
    |=> st_r == ST_GUARD2) else $error("escape step not closed");
  a_guard_quiet: assert property (st_r inside {ST_GUARD1, ST_GUARD2} && st_nxt != st_r
    |-> f_empty && tmr_r >= guard_lim) else $error("guard cut short");
  a_disc_end: assert property (st_r == ST_DISC && idx_r >= len_r[STR_DISC]
    |=> st_r == ST_IDLE ##1 (st_r == ST_IDLE || $past(dial_req || hang_req || ring_rise)))
    else $error("disconnect step did not finish");
  a_lost_ready: assert property (st_r == ST_ONLINE && !set_ready_s && !hang_req
    |=> !link_up && lost_r) else $error("lost set-ready not flagged");
  a_hang_order: assert property (st_r == ST_GUARD2 && guard_done
    |=> st_r == ST_DISC) else $error("hang-up order broken");

  c_dial_online: cover property (st_r == ST_WAIT ##1 st_r == ST_ONLINE);
  c_timeout: cover property ($rose(timeout_r));
  c_user_hang: cover property (st_r == ST_GUARD1 ##[1:1000] st_r == ST_DISC);
  c_lost: cover property ($rose(lost_r));
endmodule

/* shared/smcc_pkg.sv */
/*
  Constants, types and helpers for the modem call-control sequencer.
  Assumes a 125 MHz clock and the register port of smcc_top.
*/
// What this block does
// - Command set off: no command bytes ever go out; the code still sends ATH on a hang-up during a call.
// - Standard command set: each command ends with CR then LF.
// - Prefix, connect string, escape, guard and disconnect only apply in user mode.
// - Dial-in enabled answers incoming calls; disabled leaves them unanswered.
// - Dial sends prefix (max 20) before the number; none when cleared.
// - After dialing, search received data for connect string; time out after 1 minute.
// - Connect string cleared: no search, carrier detect means connected.
// - Before hanging up, send escape sequence (max 20); nothing when cleared.
// - Line silent for guard delay before and after escape; none or 0.2-1.0 s.
// - Send disconnect string (max 20) to make the modem hang up.
// - Caret notation, case-insensitive, maps to control bytes 0x00-0x1F, ESC 0x1B.
// - Loss of the set-ready lead means the connection is lost.
package smcc_pkg;
  localparam longint unsigned CLK_HZ        = 125_000_000;
  localparam longint unsigned CONN_TMO_S    = 60;
  localparam longint unsigned GUARD_STEP_MS = 200;
  localparam logic [33:0] CONN_TMO_CYC   = 34'(CLK_HZ * CONN_TMO_S);
  localparam logic [31:0] GUARD_STEP_CYC = 32'(CLK_HZ * GUARD_STEP_MS / 1000);
  localparam logic [2:0]  GUARD_MAX      = 3'h5;

  localparam int STR_MAX = 20;
  localparam int NSTR    = 5;
  localparam logic [2:0] STR_PRE  = 3'h0;
  localparam logic [2:0] STR_CONN = 3'h1;
  localparam logic [2:0] STR_ESC  = 3'h2;
  localparam logic [2:0] STR_DISC = 3'h3;
  localparam logic [2:0] STR_NUM  = 3'h4;

  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CMD  = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_STR  = 8'h0C;
  localparam logic [7:0] REG_LEN  = 8'h10;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_DIALIN   = 2;
  localparam int CTRL_GUARD_LSB = 3;
  localparam int CMD_DIAL = 0;
  localparam int CMD_HANG = 1;
  localparam int STR_SEL_LSB = 8;
  localparam int STR_CLR = 11;
  localparam int STAT_UP = 4;
  localparam int STAT_TMO = 5;
  localparam int STAT_LOST = 6;
  localparam int STAT_BUSY = 7;
  localparam int LEN_STRIDE = 6;

  localparam logic [1:0] MODE_OFF  = 2'h0;
  localparam logic [1:0] MODE_STD  = 2'h1;
  localparam logic [1:0] MODE_USER = 2'h2;

  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [7:0] CH_CARET = 8'h5E;
  localparam logic [7:0] CH_CTL_LO = 8'h40;
  localparam logic [7:0] CTL_MASK = 8'h1F;
  localparam logic [4:0] STD_CMD_LEN = 5'h03;

  typedef enum logic [1:0] {OP_DIAL, OP_ANS, OP_HANG} smcc_op_e;

  function automatic logic [7:0] smcc_std_byte(smcc_op_e op, logic [4:0] idx);
    logic [7:0] b;
    b = 8'h41;
    if (idx == 5'h01) b = 8'h54;
    else if (idx != 5'h00) b = (op == OP_DIAL) ? 8'h44 : (op == OP_ANS) ? 8'h41 : 8'h48;
    return b;
  endfunction
endpackage

/* hw/smcc_fifo.sv */
/*
  Small FIFO with valid/ready on both sides.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/100ps
module smcc_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  logic [W-1:0] mem_r [D];
  logic [AW-1:0] wp_r, rp_r;
  logic [AW:0]   cnt_r;
  logic          wr, rd;

  assign in_ready  = (cnt_r != (AW+1)'(D));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rp_r];
  assign wr = in_valid && in_ready;
  assign rd = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (wr) mem_r[wp_r] <= in_data;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (wr) wp_r <= (wp_r == AW'(D-1)) ? '0 : wp_r + 1'b1;
      if (rd) rp_r <= (rp_r == AW'(D-1)) ? '0 : rp_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(wr) - (AW+1)'(rd);
    end
  end
endmodule

/* hw/smcc_caret.sv */
/*
  Caret-notation decoder for characters written into the string store.
  Assumes one character offered per write pulse, same clock.
*/
`timescale 1ns/100ps
module smcc_caret import smcc_pkg::*; (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       in_wr,
  input  wire logic [7:0] in_char,
  input  wire logic       in_clr,
  output logic            out_wr,
  output logic [7:0]      out_byte
);
  logic pend_r;

  always_comb begin
    out_wr   = in_wr && !in_clr && (pend_r || in_char != CH_CARET);
    out_byte = in_char;
    if (pend_r && in_char >= CH_CTL_LO) out_byte = in_char & CTL_MASK;
  end

  always_ff @(posedge clk) begin
    if (srst || in_clr) pend_r <= 1'b0;
    else if (in_wr) pend_r <= !pend_r && in_char == CH_CARET;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  a_caret_ctl: assert property (pend_r && in_wr && !in_clr && in_char >= CH_CTL_LO |->
    out_wr && out_byte <= CTL_MASK && out_byte[4:0] == in_char[4:0]) else $error("caret pair not decoded");
endmodule

/* test/smcc_modem.sv */
/*
  Behavioural modem on the far side of smcc_top: takes tx bytes, answers on rx.
  Assumes the bench steers line state, tx stalls and the ring lead.
*/
`timescale 1ns/100ps
module smcc_modem (
  input  wire logic       clk,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  output logic [7:0]      rx_data,
  output logic            rx_valid,
  output logic            cd_pin,
  output logic            set_ready_pin,
  output logic            ring_pin,
  input  wire logic       stall,
  input  wire logic       line,
  input  wire logic       sr_loss,
  input  wire logic       ring
);
  logic [7:0] got[$];
  int         gt[$];
  int         cyc = 0;

  initial begin
    rx_data  = 8'hA5;
    rx_valid = 1'b0;
  end

  ////////////////////////////////////////////////////////////////
  assign tx_ready = !stall;
  assign ring_pin = ring;
  assign cd_pin = line;
  // set-ready drops with the call; our ready lead is not even wired in
  assign set_ready_pin = line && !sr_loss;

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (tx_valid && tx_ready) begin
      got.push_back(tx_data);
      gt.push_back(cyc);
    end
  end

  // idle rx data flips so a stale byte is never mistaken for a fresh one
  task automatic say(string s);
    for (int i = 0; i < s.len(); i++) begin
      @(posedge clk);
      rx_data  <= s[i];
      rx_valid <= 1'b1;
      @(posedge clk);
      rx_data  <= ~s[i];
      rx_valid <= 1'b0;
    end
  endtask
endmodule

/* test/smcc_top_tb.sv */
/*
  Self-checking bench for smcc_top talking to the smcc_modem model.
  Assumes timeout and guard counts shortened through the parameters.
*/
`timescale 1ns/100ps
module smcc_top_tb import smcc_pkg::*; ;
  localparam int GS = 10;
  logic        clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic        stall = 1'b0, line = 1'b0, sr_loss = 1'b0, ring = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic [7:0]  tx_data, rx_data;
  logic        tx_valid, tx_ready, rx_valid, cd_pin, set_ready_pin, ring_pin, link_up;
  int          fails = 0, compares = 0, t0;

  initial begin
    forever #4 clk = ~clk;
  end

  smcc_top #(.TMO_CYC(34'h0C8), .GSTEP_CYC(32'h0000000A), .FIFO_D(4)) dut_u (
    .clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .tx_data, .tx_valid,
    .tx_ready, .rx_data, .rx_valid, .cd_pin, .set_ready_pin, .ring_pin, .link_up);

  smcc_modem modem_u (
    .clk, .tx_data, .tx_valid, .tx_ready, .rx_data, .rx_valid, .cd_pin, .set_ready_pin,
    .ring_pin, .stall, .line, .sr_loss, .ring);

  ////////////////////////////////////////////////////////////////
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("counts: %0d compares, %0d fails", compares, fails);
    if (fails == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rc(string what, logic [7:0] a, logic [31:0] m, logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 chk(what, reg_rdata & m, e);
  endtask

  task automatic put(logic [2:0] sel, string s);
    wr(REG_STR, (32'(sel) << STR_SEL_LSB) | (32'h1 << STR_CLR));
    for (int i = 0; i < s.len(); i++) wr(REG_STR, (32'(sel) << STR_SEL_LSB) | 32'(s[i]));
  endtask

  task automatic go(logic [31:0] c);
    modem_u.got.delete();
    modem_u.gt.delete();
    wr(REG_CMD, c);
    t0 = modem_u.cyc;
  endtask

  task automatic ring_call();
    modem_u.got.delete();
    @(posedge clk) ring <= 1'b1;
    repeat (4) @(posedge clk);
    ring <= 1'b0;
  endtask

  // waits for the bytes, then lingers so a stray extra byte is seen too
  task automatic expect_tx(string what, string s);
    int n;
    n = 0;
    while (modem_u.got.size() < s.len() && n < 3000) begin
      @(posedge clk);
      n++;
    end
    repeat (40) @(posedge clk);
    chk({what, " count"}, modem_u.got.size(), s.len());
    for (int i = 0; i < s.len() && i < modem_u.got.size(); i++) chk(what, modem_u.got[i], s[i]);
  endtask

  task automatic fin(string name);
    $display("test %s done", name);
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    test_done();
  end

  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    rc("ctrl", REG_CTRL, 32'hFFFFFFFF, 32'h0);
    rc("stat", REG_STAT, 32'hFFFFFFFF, 32'h0);
    rc("len", REG_LEN, 32'hFFFFFFFF, 32'h0);
    rc("hole", 8'h14, 32'hFFFFFFFF, 32'h0);
    fin("reset");
    put(STR_NUM, "5");
    put(STR_PRE, "X");
    go(32'h1);
    expect_tx("off", "");
    fin("off");
    wr(REG_CTRL, 32'h1);
    stall <= 1'b1;
    go(32'h1);
    repeat (20) @(posedge clk);
    chk("stalled", modem_u.got.size(), 0);
    rc("busy", REG_STAT, 32'h80, 32'h80);
    @(posedge clk) stall <= 1'b0;
    expect_tx("std dial", "ATD5\015\012");
    line <= 1'b1;
    repeat (8) @(posedge clk);
    rc("up", REG_STAT, 32'h10, 32'h10);
    chk("link", link_up, 1'b1);
    @(posedge clk) sr_loss <= 1'b1;
    repeat (8) @(posedge clk);
    rc("lost", REG_STAT, 32'h50, 32'h40);
    wr(REG_STAT, 32'h40);
    line    <= 1'b0;
    sr_loss <= 1'b0;
    rc("lost clr", REG_STAT, 32'h40, 32'h0);
    fin("std dial");
    ring_call();
    expect_tx("no answer", "");
    wr(REG_CTRL, 32'h5);
    ring_call();
    expect_tx("answer", "ATA\015\012");
    line <= 1'b1;
    repeat (8) @(posedge clk);
    go(32'h2);
    expect_tx("std hang", "ATH\015\012");
    line <= 1'b0;
    rc("idle", REG_STAT, 32'h1F, 32'h0);
    fin("std answer");
    // two guard steps, above the modem's own escape guard time
    wr(REG_CTRL, 32'h12);
    put(STR_PRE, "^b^[");
    rc("pre len", REG_LEN, 32'h1F, 32'h2);
    put(STR_CONN, "OK");
    put(STR_ESC, "+++");
    put(STR_DISC, "H");
    go(32'h1);
    expect_tx("user dial", "\002\0335");
    line <= 1'b1;
    repeat (8) @(posedge clk);
    rc("no cd", REG_STAT, 32'h1F, 32'h05);
    modem_u.say("OK");
    repeat (8) @(posedge clk);
    rc("str up", REG_STAT, 32'h10, 32'h10);
    go(32'h2);
    expect_tx("user hang", "+++H");
    chk("guard1", modem_u.gt[0] - t0 >= 2 * GS, 1'b1);
    chk("guard2", modem_u.gt[3] - modem_u.gt[2] >= 2 * GS, 1'b1);
    line <= 1'b0;
    fin("user call");
    go(32'h1);
    expect_tx("redial", "\002\0335");
    rc("no tmo", REG_STAT, 32'h20, 32'h0);
    repeat (250) @(posedge clk);
    rc("tmo", REG_STAT, 32'h20, 32'h20);
    wr(REG_STAT, 32'h20);
    rc("tmo clr", REG_STAT, 32'h20, 32'h0);
    fin("timeout");
    wr(REG_CTRL, 32'h2);
    put(STR_PRE, "");
    put(STR_CONN, "");
    put(STR_ESC, "");
    go(32'h1);
    expect_tx("bare dial", "5");
    line <= 1'b1;
    repeat (8) @(posedge clk);
    rc("cd up", REG_STAT, 32'h10, 32'h10);
    go(32'h2);
    expect_tx("bare hang", "H");
    line <= 1'b0;
    fin("cleared");
    test_done();
  end
endmodule
